// >>> core/hdbbp_map.svh
// Bit positions, widths and reset values of the host data bus buffer port
`ifndef HDBBP_MAP_SVH
`define HDBBP_MAP_SVH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define HDBBP_BYTE_W      8
`define HDBBP_NIB_W       4
`define HDBBP_SYNC_W      12

// ----------------------------------------------------------------------
// Status byte field positions
// ----------------------------------------------------------------------
`define HDBBP_ST_OBF      0
`define HDBBP_ST_IBF      1
`define HDBBP_ST_F0       2
`define HDBBP_ST_F1       3
`define HDBBP_ST_USR_LO   4
`define HDBBP_ST_USR_HI   7

// ----------------------------------------------------------------------
// Positions inside the synchroniser vector
// ----------------------------------------------------------------------
`define HDBBP_SY_CS       0
`define HDBBP_SY_RD       1
`define HDBBP_SY_WR       2
`define HDBBP_SY_SEL      3
`define HDBBP_SY_DAT_LO   4
`define HDBBP_SY_DAT_HI   11

// ----------------------------------------------------------------------
// Reset values and the command select level
// ----------------------------------------------------------------------
`define HDBBP_BYTE_RST    8'h00
`define HDBBP_NIB_RST     4'h0
`define HDBBP_SYNC_RST    12'h007
`define HDBBP_SEL_CMD     1'b1

`endif

// >>> core/hdbbp_pkg.sv
// Types shared by the host data bus buffer port modules
package hdbbp_pkg;
  `include "hdbbp_map.svh"

  typedef logic [`HDBBP_BYTE_W-1:0] hdbbp_byte_t;
  typedef logic [`HDBBP_NIB_W-1:0]  hdbbp_nib_t;
  typedef logic [`HDBBP_SYNC_W-1:0] hdbbp_sync_t;

  // Host cycle tracker
  typedef enum logic [1:0] {
    HDBBP_IDLE   = 2'b00,
    HDBBP_RD_OUT = 2'b01,
    HDBBP_RD_STS = 2'b10,
    HDBBP_WRITE  = 2'b11
  } hdbbp_state_t;
endpackage

// >>> core/hdbbp_sync_if.sv
// Carrier between the pin synchroniser and the port core
interface hdbbp_sync_if;
  import hdbbp_pkg::*;
  hdbbp_sync_t raw;
  hdbbp_sync_t clean;
  modport sampler (input raw, output clean);
  modport core    (output raw, input clean);
endinterface

// >>> core/hdbbp_sync.sv
// Three-stage pin synchroniser with agreement filter
`include "hdbbp_map.svh"
module hdbbp_sync (
  // Clock and control
  input  wire logic         mclk,
  input  wire logic         srst,
  input  wire logic         ce,
  // Pin vector
  hdbbp_sync_if.sampler     sy
);
  import hdbbp_pkg::*;

  localparam hdbbp_sync_t sync_rst = `HDBBP_SYNC_RST;

  hdbbp_sync_t meta_q;
  hdbbp_sync_t st2_q;
  hdbbp_sync_t st3_q;
  hdbbp_sync_t clean_q;

  // First stage feeds only the second stage
  always_ff @(posedge mclk) begin
    if (srst) begin
      meta_q <= `HDBBP_SYNC_RST;
      st2_q  <= `HDBBP_SYNC_RST;
      st3_q  <= `HDBBP_SYNC_RST;
    end else if (ce) begin
      meta_q <= sy.raw;
      st2_q  <= meta_q;
      st3_q  <= st2_q;
    end
  end

  // A bit changes only once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < `HDBBP_SYNC_W; gi++) begin : g_bit
      always_ff @(posedge mclk) begin
        if (srst) begin
          clean_q[gi] <= sync_rst[gi];
        end else if (ce && (st2_q[gi] == st3_q[gi])) begin
          clean_q[gi] <= st3_q[gi];
        end
      end
    end
  endgenerate

  assign sy.clean = clean_q;
endmodule

// >>> core/hdbbp_top.sv
// Host data bus buffer port: two byte buffers and a status byte behind host strobes
`include "hdbbp_map.svh"
module hdbbp_top
  import hdbbp_pkg::*;
(
  // Clock, reset, enable
  input  wire logic               mclk,
  input  wire logic               srst,
  input  wire logic               ce,
  // Host bus pins
  input  wire logic               host_cs_n,
  input  wire logic               host_rd_n,
  input  wire logic               host_wr_n,
  input  wire logic               register_select,
  input  wire hdbbp_pkg::hdbbp_byte_t host_data_in,
  output      hdbbp_pkg::hdbbp_byte_t host_data_out,
  output      logic               host_data_oe_n,
  // Program side: output buffer
  input  wire logic               obuf_load,
  input  wire hdbbp_pkg::hdbbp_byte_t obuf_data,
  // Program side: input buffer
  input  wire logic               ibuf_read,
  output      hdbbp_pkg::hdbbp_byte_t ibuf_data,
  // Program side: flags and status
  input  wire logic               user_flag_clear,
  input  wire logic               user_flag_toggle,
  input  wire logic               cmd_flag_clear,
  input  wire logic               cmd_flag_toggle,
  input  wire logic               load_status_instruction,
  input  wire hdbbp_pkg::hdbbp_nib_t load_status_data,
  output      hdbbp_pkg::hdbbp_byte_t host_status_byte,
  // Program side: input-full interrupt
  input  wire logic               ibf_int_enable,
  input  wire logic               ibf_service_entry,
  output      logic               ibf_int_request,
  output      logic               ibf_int_take,
  // Program side: host flag lines
  input  wire logic               host_flags_enable,
  input  wire logic               obf_line_level,
  input  wire logic               ibe_line_level,
  output      logic               host_obf_line,
  output      logic               host_ibe_line
);
  import hdbbp_pkg::*;

  // --------------------------------------------------------------------
  // Pin synchronisation
  // --------------------------------------------------------------------
  hdbbp_sync_if sy ();

  assign sy.raw = {host_data_in, register_select, host_wr_n, host_rd_n, host_cs_n};

  hdbbp_sync u_sync (
    .mclk (mclk),
    .srst (srst),
    .ce   (ce),
    .sy   (sy.sampler)
  );

  logic        cs_s;
  logic        rd_s;
  logic        wr_s;
  logic        sel_s;
  hdbbp_byte_t dat_s;

  // Active-low strobes turned into active-high selects
  assign cs_s  = ~sy.clean[`HDBBP_SY_CS];
  assign rd_s  = ~sy.clean[`HDBBP_SY_RD];
  assign wr_s  = ~sy.clean[`HDBBP_SY_WR];
  assign sel_s = sy.clean[`HDBBP_SY_SEL];
  assign dat_s = sy.clean[`HDBBP_SY_DAT_HI:`HDBBP_SY_DAT_LO];

  // --------------------------------------------------------------------
  // Host cycle decode
  // --------------------------------------------------------------------
  logic sel_read;
  logic sel_write;

  // Chip select gates everything; both strobes together is not a cycle
  assign sel_read  = cs_s & rd_s & ~wr_s;
  assign sel_write = cs_s & wr_s & ~rd_s;

  hdbbp_state_t state_q;
  hdbbp_state_t state_d;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      HDBBP_IDLE: begin
        if (sel_read) begin
          state_d = sel_s ? HDBBP_RD_STS : HDBBP_RD_OUT;
        end else if (sel_write) begin
          state_d = HDBBP_WRITE;
        end
      end
      HDBBP_RD_OUT: begin
        if (!sel_read) begin
          state_d = HDBBP_IDLE;
        end
      end
      HDBBP_RD_STS: begin
        if (!sel_read) begin
          state_d = HDBBP_IDLE;
        end
      end
      HDBBP_WRITE: begin
        if (!sel_write) begin
          state_d = HDBBP_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q <= HDBBP_IDLE;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  logic rd_out_start;
  logic rd_sts_start;
  logic wr_done;

  assign rd_out_start = (state_q == HDBBP_IDLE) && (state_d == HDBBP_RD_OUT);
  assign rd_sts_start = (state_q == HDBBP_IDLE) && (state_d == HDBBP_RD_STS);
  // Data and select are taken at the end of the strobe, when they are settled
  assign wr_done      = (state_q == HDBBP_WRITE) && (state_d == HDBBP_IDLE);

  // --------------------------------------------------------------------
  // Buffers
  // --------------------------------------------------------------------
  hdbbp_byte_t obuf_q;
  hdbbp_byte_t ibuf_q;

  always_ff @(posedge mclk) begin
    if (srst) begin
      obuf_q <= `HDBBP_BYTE_RST;
    end else if (ce && obuf_load) begin
      obuf_q <= obuf_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      ibuf_q <= `HDBBP_BYTE_RST;
    end else if (ce && wr_done) begin
      ibuf_q <= dat_s;
    end
  end

  assign ibuf_data = ibuf_q;

  // --------------------------------------------------------------------
  // Status flags
  // --------------------------------------------------------------------
  logic       obf_q;
  logic       ibf_q;
  logic       f0_q;
  logic       f1_q;
  hdbbp_nib_t usr_q;

  // Program load wins over a host read in the same cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      obf_q <= 1'b0;
    end else if (ce) begin
      if (obuf_load) begin
        obf_q <= 1'b1;
      end else if (rd_out_start) begin
        obf_q <= 1'b0;
      end
    end
  end

  // Host write wins over a program read in the same cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      ibf_q <= 1'b0;
    end else if (ce) begin
      if (wr_done) begin
        ibf_q <= 1'b1;
      end else if (ibuf_read) begin
        ibf_q <= 1'b0;
      end
    end
  end

  // Host has no path to this flag
  always_ff @(posedge mclk) begin
    if (srst) begin
      f0_q <= 1'b0;
    end else if (ce) begin
      if (user_flag_clear) begin
        f0_q <= 1'b0;
      end else if (user_flag_toggle) begin
        f0_q <= ~f0_q;
      end
    end
  end

  // Host write beats a program change in the same cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      f1_q <= 1'b0;
    end else if (ce) begin
      if (wr_done) begin
        f1_q <= (sel_s == `HDBBP_SEL_CMD);
      end else if (cmd_flag_clear) begin
        f1_q <= 1'b0;
      end else if (cmd_flag_toggle) begin
        f1_q <= ~f1_q;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      usr_q <= `HDBBP_NIB_RST;
    end else if (ce && load_status_instruction) begin
      usr_q <= load_status_data;
    end
  end

  hdbbp_byte_t status_w;

  always_comb begin
    status_w                                    = `HDBBP_BYTE_RST;
    status_w[`HDBBP_ST_OBF]                     = obf_q;
    status_w[`HDBBP_ST_IBF]                     = ibf_q;
    status_w[`HDBBP_ST_F0]                      = f0_q;
    status_w[`HDBBP_ST_F1]                      = f1_q;
    status_w[`HDBBP_ST_USR_HI:`HDBBP_ST_USR_LO] = usr_q;
  end

  assign host_status_byte = status_w;

  // --------------------------------------------------------------------
  // Host data bus drive
  // --------------------------------------------------------------------
  hdbbp_byte_t dout_q;
  logic        oe_n_q;

  // Byte is frozen at read start so the bus holds steady for the strobe
  always_ff @(posedge mclk) begin
    if (srst) begin
      dout_q <= `HDBBP_BYTE_RST;
    end else if (ce) begin
      if (rd_out_start) begin
        dout_q <= obuf_q;
      end else if (rd_sts_start) begin
        dout_q <= status_w;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      oe_n_q <= 1'b1;
    end else if (ce) begin
      oe_n_q <= ~((state_d == HDBBP_RD_OUT) || (state_d == HDBBP_RD_STS));
    end
  end

  assign host_data_out  = dout_q;
  assign host_data_oe_n = oe_n_q;

  // --------------------------------------------------------------------
  // Input-full interrupt request
  // --------------------------------------------------------------------
  logic irq_q;

  // Raised regardless of enable; only service entry clears, raise wins
  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_q <= 1'b0;
    end else if (ce) begin
      if (cs_s && wr_s) begin
        irq_q <= 1'b1;
      end else if (ibf_service_entry) begin
        irq_q <= 1'b0;
      end
    end
  end

  assign ibf_int_request = irq_q;
  assign ibf_int_take    = irq_q & ibf_int_enable;

  // --------------------------------------------------------------------
  // Host flag lines
  // --------------------------------------------------------------------
  logic flags_en_q;

  always_ff @(posedge mclk) begin
    if (srst) begin
      flags_en_q <= 1'b0;
    end else if (ce && host_flags_enable) begin
      flags_en_q <= 1'b1;
    end
  end

  // Port latch level still gates the line so the program can mask it
  assign host_obf_line = flags_en_q ? (obf_q & obf_line_level) : obf_line_level;
  assign host_ibe_line = flags_en_q ? (~ibf_q & ibe_line_level) : ibe_line_level;
endmodule

// >>> sim/hdbbp_properties.sv
// Pin-level checks on the host data bus buffer port
module hdbbp_properties
  import hdbbp_pkg::*;
(
  // Clock and reset
  input wire logic                   mclk,
  input wire logic                   srst,
  input wire logic                   ce,
  // Host bus
  input wire logic                   host_cs_n,
  input wire logic                   host_rd_n,
  input wire logic                   host_wr_n,
  input wire logic                   host_data_oe_n,
  // Program side
  input wire logic                   obuf_load,
  input wire logic                   ibuf_read,
  input wire logic                   user_flag_clear,
  input wire logic                   user_flag_toggle,
  input wire logic                   load_status_instruction,
  input wire hdbbp_pkg::hdbbp_nib_t  load_status_data,
  input wire hdbbp_pkg::hdbbp_byte_t host_status_byte,
  input wire logic                   ibf_int_request,
  // Host flag lines
  input wire logic                   host_flags_enable,
  input wire logic                   obf_line_level,
  input wire logic                   ibe_line_level,
  input wire logic                   host_obf_line,
  input wire logic                   host_ibe_line
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking @(posedge mclk); endclocking
  default disable iff (srst);

  // ----
  // Helpers
  // ----
  logic [3:0] wr_age_q;
  logic       fen_q;
  // Ages the last write so a pending capture is not mistaken for a miss
  always_ff @(posedge mclk) begin
    if (srst || !host_wr_n) wr_age_q <= 4'h0;
    else if (wr_age_q != 4'hF) wr_age_q <= wr_age_q + 4'h1;
  end
  always_ff @(posedge mclk) begin
    if (srst) fen_q <= 1'b0;
    else if (host_flags_enable && ce) fen_q <= 1'b1;
  end
  sequence sel_rd_s; !host_cs_n && !host_rd_n && host_wr_n; endsequence
  sequence sel_wr_s; !host_cs_n && !host_wr_n; endsequence

  // ----
  // Properties
  // ----
  oe_unsel_a: assert property (host_cs_n [*8] |-> host_data_oe_n)
    else $error("bus driven while deselected");
  rd_drive_a: assert property (sel_rd_s [*8] |-> !host_data_oe_n)
    else $error("selected read not driven");
  obf_set_a: assert property (obuf_load && ce |=> host_status_byte[0])
    else $error("output-full not set");
  ibf_clr_a: assert property (ibuf_read && wr_age_q > 4'h9 |=> !host_status_byte[1])
    else $error("input-full not cleared");
  usr_load_a: assert property (load_status_instruction |=>
    host_status_byte[7:4] == $past(load_status_data))
    else $error("user bits not loaded");
  f0_clr_a: assert property (user_flag_clear |=> !host_status_byte[2])
    else $error("user flag not cleared");
  f0_tgl_a: assert property (user_flag_toggle && !user_flag_clear |=>
    host_status_byte[2] != $past(host_status_byte[2]))
    else $error("user flag not toggled");
  irq_raise_a: assert property (sel_wr_s [*7] |-> ibf_int_request)
    else $error("write request not raised");
  flag_line_a: assert property (
    host_obf_line == (fen_q ? host_status_byte[0] & obf_line_level : obf_line_level) &&
    host_ibe_line == (fen_q ? !host_status_byte[1] & ibe_line_level : ibe_line_level))
    else $error("host flag line wrong");
endmodule

bind hdbbp_top hdbbp_properties hdbbp_properties_inst (.mclk, .srst, .ce, .host_cs_n,
  .host_rd_n, .host_wr_n, .host_data_oe_n, .obuf_load, .ibuf_read, .user_flag_clear,
  .user_flag_toggle, .load_status_instruction, .load_status_data, .host_status_byte,
  .ibf_int_request, .host_flags_enable, .obf_line_level, .ibe_line_level,
  .host_obf_line, .host_ibe_line);

// >>> sim/hdbbp_host_model.sv
// Master processor model driving the host strobes and the shared data wire
module hdbbp_host_model
  import hdbbp_pkg::*;
(
  // Clock
  input wire logic         mclk,
  // Device drive
  input wire hdbbp_byte_t  dev_data,
  input wire logic         dev_oe_n,
  // Host bus
  output logic             cs_n,
  output logic             rd_n,
  output logic             wr_n,
  output logic             sel,
  output hdbbp_byte_t      bus
);
  timeunit 1ns;
  timeprecision 100ps;

  hdbbp_byte_t hdat;
  hdbbp_byte_t last;
  logic        hdrv;
  initial begin
    {cs_n, rd_n, wr_n, sel, hdrv} = 5'h1C;
    {hdat, last} = 16'h0000;
  end
  // Floating wire shows the inverse of its last level
  always @(posedge mclk) last <= bus;
  assign bus = (dev_oe_n === 1'b0) ? dev_data : hdrv ? hdat : ~last;

  // Strobes active low, never both while selected
  task automatic hrd(input logic s, output hdbbp_byte_t d);
    int n;
    @(posedge mclk);
    sel <= s;
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    n = 0;
    while (dev_oe_n !== 1'b0 && n < 30) begin
      @(posedge mclk);
      n++;
    end
    repeat (4) @(posedge mclk);
    d = bus;
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (8) @(posedge mclk);
  endtask
  task automatic hwr(input logic s, input hdbbp_byte_t d);
    @(posedge mclk);
    sel <= s;
    hdat <= d;
    hdrv <= 1'b1;
    cs_n <= 1'b0;
    wr_n <= 1'b0;
    repeat (8) @(posedge mclk);
    wr_n <= 1'b1;
    repeat (6) @(posedge mclk);
    cs_n <= 1'b1;
    hdrv <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask
  // Strobes waved with the chip deselected
  task automatic ghost();
    @(posedge mclk);
    {rd_n, wr_n, sel} <= 3'h1;
    repeat (10) @(posedge mclk);
    {rd_n, wr_n} <= 2'h3;
    repeat (8) @(posedge mclk);
  endtask
endmodule

// >>> sim/hdbbp_top_tb.sv
// Self-checking bench for the host data bus buffer port
module hdbbp_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import hdbbp_pkg::*;
  logic        mclk, srst, ce, cs_n, rd_n, wr_n, sel, oe_n, req, take, ien, ln_o, ln_i;
  logic [1:0]  lvl;
  logic [8:0]  pg;
  hdbbp_byte_t bus, dout, obuf_d, ibuf_d, sts, d;
  hdbbp_nib_t  ld_d;
  int          n_fail, checked, cyc;

  hdbbp_top hdbbp_top_inst (.mclk(mclk), .srst(srst), .ce(ce), .host_cs_n(cs_n),
    .host_rd_n(rd_n), .host_wr_n(wr_n), .register_select(sel), .host_data_in(bus),
    .host_data_out(dout), .host_data_oe_n(oe_n), .obuf_load(pg[8]), .obuf_data(obuf_d),
    .ibuf_read(pg[7]), .ibuf_data(ibuf_d), .user_flag_clear(pg[6]),
    .user_flag_toggle(pg[5]), .cmd_flag_clear(pg[4]), .cmd_flag_toggle(pg[3]),
    .load_status_instruction(pg[2]), .load_status_data(ld_d), .host_status_byte(sts),
    .ibf_int_enable(ien), .ibf_service_entry(pg[1]), .ibf_int_request(req),
    .ibf_int_take(take), .host_flags_enable(pg[0]), .obf_line_level(lvl[1]),
    .ibe_line_level(lvl[0]), .host_obf_line(ln_o), .host_ibe_line(ln_i));
  hdbbp_host_model hdbbp_host_model_inst (.mclk(mclk), .dev_data(dout), .dev_oe_n(oe_n),
    .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .sel(sel), .bus(bus));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic chk(input hdbbp_byte_t seen, input hdbbp_byte_t exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic pulse(input logic [8:0] m);
    pg <= m;
    @(posedge mclk);
    pg <= 9'h000;
    @(posedge mclk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Run is about 190 cycles; ceiling leaves wide margin
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      report_and_stop();
    end
  end

  initial begin
    {srst, ce, ien, lvl, pg, obuf_d, ld_d} = {2'h3, 3'h3, 9'h000, 8'h00, 4'h0};
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    chk(sts, 8'h00);
    obuf_d <= 8'hA5;
    pulse(9'h100);
    hdbbp_host_model_inst.hrd(1'b1, d);
    chk(d, 8'h01);
    hdbbp_host_model_inst.hrd(1'b0, d);
    chk(d, 8'hA5);
    hdbbp_host_model_inst.hrd(1'b1, d);
    chk(d, 8'h00);
    $display("test output buffer done");
    for (int i = 0; i < 2; i++) begin
      ien <= i[0];
      hdbbp_host_model_inst.hwr(i[0], i[0] ? 8'hC3 : 8'h3C);
      chk(ibuf_d, i[0] ? 8'hC3 : 8'h3C);
      chk(sts, {4'h0, i[0], 3'h2});
      chk({6'h00, req, take}, {6'h00, 1'b1, i[0]});
      pulse(9'h002);
      chk({7'h00, req}, 8'h00);
      pulse(9'h080);
      chk(sts, {4'h0, i[0], 3'h0});
    end
    $display("test host write done");
    ld_d <= 4'h9;
    pulse(9'h02C);
    hdbbp_host_model_inst.hrd(1'b1, d);
    chk(d, 8'h94);
    pulse(9'h068);
    chk(sts, 8'h98);
    pulse(9'h018);
    hdbbp_host_model_inst.ghost();
    chk({sts[7:1], oe_n}, 8'h91);
    chk({7'h00, req}, 8'h00);
    ce <= 1'b0;
    pulse(9'h100);
    chk(sts, 8'h90);
    ce <= 1'b1;
    $display("test program flags done");
    pulse(9'h101);
    chk({6'h00, ln_o, ln_i}, 8'h03);
    lvl <= 2'h1;
    @(posedge mclk);
    @(posedge mclk);
    chk({6'h00, ln_o, ln_i}, 8'h01);
    lvl <= 2'h3;
    hdbbp_host_model_inst.hrd(1'b0, d);
    chk(d, 8'hA5);
    chk({6'h00, ln_o, ln_i}, 8'h01);
    $display("test flag lines done");
    report_and_stop();
  end
endmodule
